// ### rtl/blit_pkg.sv
// shared constants and types for the bit-aligned block transfer engine
package blit_pkg;

	// memory word and register port geometry: bit 0 of a word is the first pixel shown
	localparam int WORD_W     = 16;
	localparam int WORD_SH    = 4;
	localparam int REG_DATA_W = 32;
	localparam int REG_ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_SRC_ORG = 8'h04;
	localparam logic [7:0] OFS_DST_ORG = 8'h08;
	localparam logic [7:0] OFS_PITCH   = 8'h0C;
	localparam logic [7:0] OFS_WIDTH   = 8'h10;
	localparam logic [7:0] OFS_HEIGHT  = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_MASKS   = 8'h1C;
	localparam logic [7:0] OFS_SHIFT   = 8'h20;

	// control register fields
	localparam int CTRL_START  = 0;
	localparam int CTRL_OP_LO  = 1;
	localparam int CTRL_OP_HI  = 3;
	localparam int CTRL_INVERT = 4;
	localparam int CTRL_H_REV  = 5;
	localparam int CTRL_V_REV  = 6;

	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

	// reset values
	localparam logic [15:0] MASK_ALL   = 16'hFFFF;
	localparam logic [15:0] WORD_ZERO  = 16'h0000;
	localparam logic [31:0] REG_ZERO   = 32'h0000_0000;
	localparam logic [3:0]  SHIFT_ZERO = 4'h0;

	// seven operations: six done here, one with the external blit unit
	typedef enum logic [2:0] {
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_FAST_OR,
		OP_COPY,
		OP_WORD_OR,
		OP_EXTERNAL
	} op_type;

endpackage

// ### rtl/combine_if.sv
// signals between the sequencer and the align/combine/merge datapath
`timescale 1ns/1ps
interface combine_if;
	logic [15:0]          src_lo;
	logic [15:0]          src_hi;
	logic [15:0]          dst;
	logic [15:0]          ext;
	logic [3:0]           shift;
	logic [15:0]          mask;
	logic                 invert;
	blit_pkg::op_type     op;
	logic [15:0]          result;

	modport engine (output src_lo, src_hi, dst, ext, shift, mask, invert,
		op, input result);
	modport unit (input src_lo, src_hi, dst, ext, shift, mask, invert, op,
		output result);
endinterface

// ### rtl/blit_combine.sv
// align source, apply the logical operation and merge under the edge mask
`timescale 1ns/1ps
module blit_combine (
	combine_if.unit cif
);
	logic [31:0] window;
	logic [15:0] aligned;
	logic [15:0] src;
	logic [15:0] op_out;

	// two source words form a window; shifting it lines pixels up
	assign window  = {cif.src_hi, cif.src_lo} >> cif.shift;
	assign aligned = window[15:0];
	assign src     = cif.invert ? ~aligned : aligned;

	// bitwise operation between aligned source and destination
	assign op_out =
		(cif.op == blit_pkg::OP_AND)      ? (src & cif.dst) :
		(cif.op == blit_pkg::OP_XOR)      ? (src ^ cif.dst) :
		(cif.op == blit_pkg::OP_COPY)     ? src :
		(cif.op == blit_pkg::OP_EXTERNAL) ? cif.ext :
		(src | cif.dst);

	// zero mask bits keep the old destination bit
	assign cif.result = (op_out & cif.mask) | (cif.dst & ~cif.mask);
endmodule

// ### rtl/blit_engine.sv
// bit-aligned block transfer engine with register port and memory master
`timescale 1ns/1ps
module blit_engine #(
	parameter int ADDR_W = 24,
	parameter int DIM_W  = 16
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	// register port
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic [31:0]       i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic      [31:0]       o_reg_rdata,
	// memory master, word addressed
	output logic                   o_mem_rd,
	output logic                   o_mem_wr,
	output logic      [ADDR_W-5:0] o_mem_addr,
	output logic      [15:0]       o_mem_wdata,
	input  wire logic [15:0]       i_mem_rdata,
	input  wire logic              i_mem_ack,
	// result from the external blit unit
	input  wire logic [15:0]       i_ext_result,
	// status
	output logic                   o_busy
);
	localparam int WA_W = ADDR_W - blit_pkg::WORD_SH;

	// refuse widths the address arithmetic cannot serve; the end-bit sum
	// pads a 4-bit offset, so the dimension width needs at least 4 bits
	generate
		if (ADDR_W < 8 || ADDR_W > 32 || DIM_W < 4 || DIM_W > 24) begin : g_chk
			$error("blit_engine: unsupported ADDR_W or DIM_W");
		end
	endgenerate

	typedef enum logic [2:0] {
		S_IDLE,
		S_LINE,
		S_WORD,
		S_RD_S0,
		S_RD_S1,
		S_RD_DST,
		S_WR
	} state_type;

	state_type              state_reg;
	blit_pkg::op_type       op_reg;
	logic                   invert_reg;
	logic                   h_rev_reg;
	logic                   v_rev_reg;
	logic [ADDR_W-1:0]      src_org_reg;
	logic [ADDR_W-1:0]      dst_org_reg;
	logic [ADDR_W-1:0]      pitch_reg;
	logic [DIM_W-1:0]       width_reg;
	logic [DIM_W-1:0]       height_reg;
	logic                   done_reg;
	logic [15:0]            left_mask_reg;
	logic [15:0]            right_mask_reg;
	logic [3:0]             shift_reg;
	logic [DIM_W-1:0]       nwords_reg;
	logic [DIM_W-1:0]       y_reg;
	logic [DIM_W-1:0]       c_reg;
	logic [WA_W-1:0]        dline_reg;
	logic [WA_W-1:0]        dword_delta_reg;
	logic [15:0]            s0_reg;
	logic [15:0]            s1_reg;

	combine_if cif ();

	blit_combine blit_combine_i (
		.cif (cif)
	);

	// setup decode from the stored parameters, used only at start
	logic [DIM_W:0]    last_bit;
	logic [15:0]       left_mask_calc;
	logic [15:0]       right_mask_calc;
	logic [DIM_W-1:0]  nwords_calc;
	logic              empty_blk;
	logic              start_req;

	assign last_bit = {{(DIM_W-3){1'b0}}, dst_org_reg[3:0]}
		+ {1'b0, width_reg} - {{DIM_W{1'b0}}, 1'b1};
	assign left_mask_calc  = blit_pkg::MASK_ALL << dst_org_reg[3:0];
	assign right_mask_calc = blit_pkg::MASK_ALL >> (4'hF - last_bit[3:0]);
	assign nwords_calc     = DIM_W'(last_bit >> blit_pkg::WORD_SH)
		+ {{(DIM_W-1){1'b0}}, 1'b1};
	assign empty_blk = (width_reg == '0) || (height_reg == '0);
	assign start_req = i_reg_wr && (i_reg_addr == blit_pkg::OFS_CTRL)
		&& i_reg_wdata[blit_pkg::CTRL_START];

	// line start addresses: origin plus row times pitch, x = 0 here
	logic [DIM_W-1:0]  row;
	logic [ADDR_W-1:0] row_ofs;
	logic [ADDR_W-1:0] dst_line_bit;
	logic [ADDR_W-1:0] src_line_bit;
	logic [ADDR_W-1:0] line_delta;

	assign row = v_rev_reg ? (height_reg - DIM_W'(1) - y_reg) : y_reg;
	assign row_ofs      = ADDR_W'(row * pitch_reg);
	assign dst_line_bit = dst_org_reg + row_ofs;
	assign src_line_bit = src_org_reg + row_ofs;
	assign line_delta   = src_line_bit - dst_line_bit;

	// word walk: index counts up or down across the line
	logic [DIM_W-1:0] k_idx;
	logic [WA_W-1:0]  dst_word;
	logic [WA_W-1:0]  src_word;
	logic             first_word;
	logic             last_word;
	logic             last_step;
	logic             last_line;

	assign k_idx = h_rev_reg ? (nwords_reg - DIM_W'(1) - c_reg) : c_reg;
	assign dst_word   = dline_reg + WA_W'(k_idx);
	assign src_word   = dst_word + dword_delta_reg;
	assign first_word = (k_idx == '0);
	assign last_word  = (k_idx == nwords_reg - DIM_W'(1));
	assign last_step  = (c_reg == nwords_reg - DIM_W'(1));
	assign last_line  = (y_reg == height_reg - DIM_W'(1));

	// edge masks guard neighbouring bits; word-or assumes clean data
	logic [15:0] word_mask;

	assign word_mask = (op_reg == blit_pkg::OP_WORD_OR) ? blit_pkg::MASK_ALL :
		((first_word ? left_mask_reg : blit_pkg::MASK_ALL) &
		(last_word ? right_mask_reg : blit_pkg::MASK_ALL));

	// destination data arrives with the ack of the destination read
	assign cif.src_lo = s0_reg;
	assign cif.src_hi = s1_reg;
	assign cif.dst    = i_mem_rdata;
	assign cif.ext    = i_ext_result;
	assign cif.shift  = shift_reg;
	assign cif.mask   = word_mask;
	assign cif.invert = invert_reg;
	assign cif.op     = op_reg;

	// register read mux; unmapped offsets read as zero
	logic [31:0] rd_mux;

	assign rd_mux =
		(i_reg_addr == blit_pkg::OFS_CTRL) ? {25'h000_0000, v_rev_reg,
			h_rev_reg, invert_reg, op_reg, 1'b0} :
		(i_reg_addr == blit_pkg::OFS_SRC_ORG) ? 32'(src_org_reg) :
		(i_reg_addr == blit_pkg::OFS_DST_ORG) ? 32'(dst_org_reg) :
		(i_reg_addr == blit_pkg::OFS_PITCH)   ? 32'(pitch_reg) :
		(i_reg_addr == blit_pkg::OFS_WIDTH)   ? 32'(width_reg) :
		(i_reg_addr == blit_pkg::OFS_HEIGHT)  ? 32'(height_reg) :
		(i_reg_addr == blit_pkg::OFS_STATUS)  ? {30'h0000_0000, done_reg,
			(state_reg != S_IDLE)} :
		(i_reg_addr == blit_pkg::OFS_MASKS)   ? {right_mask_reg,
			left_mask_reg} :
		(i_reg_addr == blit_pkg::OFS_SHIFT)   ? {28'h000_0000, shift_reg} :
		blit_pkg::REG_ZERO;

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_reg_rdata <= blit_pkg::REG_ZERO;
		end else begin
			o_reg_rdata <= i_reg_rd ? rd_mux : blit_pkg::REG_ZERO;
		end
	end

	// setup writes are taken only while idle so a run sees stable values
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			op_reg      <= blit_pkg::OP_AND;
			invert_reg  <= 1'b0;
			h_rev_reg   <= 1'b0;
			v_rev_reg   <= 1'b0;
			src_org_reg <= '0;
			dst_org_reg <= '0;
			pitch_reg   <= '0;
			width_reg   <= '0;
			height_reg  <= '0;
		end else if (i_reg_wr && state_reg == S_IDLE) begin
			case (i_reg_addr)
				blit_pkg::OFS_CTRL: begin
					op_reg <= blit_pkg::op_type'(
						i_reg_wdata[blit_pkg::CTRL_OP_HI:blit_pkg::CTRL_OP_LO]);
					invert_reg <= i_reg_wdata[blit_pkg::CTRL_INVERT];
					h_rev_reg  <= i_reg_wdata[blit_pkg::CTRL_H_REV];
					v_rev_reg  <= i_reg_wdata[blit_pkg::CTRL_V_REV];
				end
				blit_pkg::OFS_SRC_ORG: src_org_reg <= i_reg_wdata[ADDR_W-1:0];
				blit_pkg::OFS_DST_ORG: dst_org_reg <= i_reg_wdata[ADDR_W-1:0];
				blit_pkg::OFS_PITCH:   pitch_reg   <= i_reg_wdata[ADDR_W-1:0];
				blit_pkg::OFS_WIDTH:   width_reg   <= i_reg_wdata[DIM_W-1:0];
				blit_pkg::OFS_HEIGHT:  height_reg  <= i_reg_wdata[DIM_W-1:0];
				default: ;
			endcase
		end
	end

	// done is sticky; a finishing run beats a clear in the same cycle
	logic finish;

	assign finish = (state_reg == S_WR) && i_mem_ack && last_step && last_line;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			done_reg <= 1'b0;
		end else if (finish || (start_req && state_reg == S_IDLE && empty_blk)) begin
			done_reg <= 1'b1;
		end else if (i_reg_wr && i_reg_addr == blit_pkg::OFS_STATUS
			&& i_reg_wdata[blit_pkg::STAT_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	// masks, shift and word count latched once at start
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			left_mask_reg  <= blit_pkg::MASK_ALL;
			right_mask_reg <= blit_pkg::MASK_ALL;
			shift_reg      <= blit_pkg::SHIFT_ZERO;
			nwords_reg     <= '0;
		end else if (start_req && state_reg == S_IDLE) begin
			left_mask_reg  <= left_mask_calc;
			right_mask_reg <= right_mask_calc;
			shift_reg      <= src_org_reg[3:0] - dst_org_reg[3:0];
			nwords_reg     <= nwords_calc;
		end
	end

	// sequencer: outer loop per line, inner loop per word
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_reg       <= S_IDLE;
			y_reg           <= '0;
			c_reg           <= '0;
			dline_reg       <= '0;
			dword_delta_reg <= '0;
			s0_reg          <= blit_pkg::WORD_ZERO;
			s1_reg          <= blit_pkg::WORD_ZERO;
			o_mem_rd        <= 1'b0;
			o_mem_wr        <= 1'b0;
			o_mem_addr      <= '0;
			o_mem_wdata     <= blit_pkg::WORD_ZERO;
			o_busy          <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (start_req && !empty_blk) begin
						y_reg     <= '0;
						o_busy    <= 1'b1;
						state_reg <= S_LINE;
					end
				end
				S_LINE: begin
					dline_reg       <= dst_line_bit[ADDR_W-1:blit_pkg::WORD_SH];
					dword_delta_reg <= line_delta[ADDR_W-1:blit_pkg::WORD_SH];
					c_reg           <= '0;
					state_reg       <= S_WORD;
				end
				S_WORD: begin
					o_mem_rd   <= 1'b1;
					o_mem_addr <= src_word;
					state_reg  <= S_RD_S0;
				end
				S_RD_S0: begin
					if (i_mem_ack) begin
						s0_reg     <= i_mem_rdata;
						o_mem_addr <= src_word + WA_W'(1);
						state_reg  <= S_RD_S1;
					end
				end
				S_RD_S1: begin
					if (i_mem_ack) begin
						s1_reg     <= i_mem_rdata;
						o_mem_addr <= dst_word;
						state_reg  <= S_RD_DST;
					end
				end
				S_RD_DST: begin
					if (i_mem_ack) begin
						o_mem_rd    <= 1'b0;
						o_mem_wr    <= 1'b1;
						o_mem_wdata <= cif.result;
						state_reg   <= S_WR;
					end
				end
				S_WR: begin
					if (i_mem_ack) begin
						o_mem_wr <= 1'b0;
						if (!last_step) begin
							c_reg     <= c_reg + DIM_W'(1);
							state_reg <= S_WORD;
						end else if (!last_line) begin
							y_reg     <= y_reg + DIM_W'(1);
							state_reg <= S_LINE;
						end else begin
							o_busy    <= 1'b0;
							state_reg <= S_IDLE;
						end
					end
				end
				default: begin
					o_mem_rd  <= 1'b0;
					o_mem_wr  <= 1'b0;
					o_busy    <= 1'b0;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// ### testbench/blit_engine_properties.sv
// port-level assertions for the block transfer engine
`timescale 1ns/1ps
module blit_engine_properties #(
	parameter int ADDR_W = 24,
	parameter int DIM_W  = 16
) (
	// clock and reset
	input wire logic              i_ref_clk,
	input wire logic              i_rstn,
	// register port
	input wire logic [7:0]        i_reg_addr,
	input wire logic [31:0]       i_reg_wdata,
	input wire logic              i_reg_wr,
	input wire logic              i_reg_rd,
	input wire logic [31:0]       o_reg_rdata,
	// memory master and external unit
	input wire logic              o_mem_rd,
	input wire logic              o_mem_wr,
	input wire logic [ADDR_W-5:0] o_mem_addr,
	input wire logic [15:0]       o_mem_wdata,
	input wire logic [15:0]       i_mem_rdata,
	input wire logic              i_mem_ack,
	input wire logic [15:0]       i_ext_result,
	// status
	input wire logic              o_busy
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// a start request as the register port sees it
	wire start_wr = i_reg_wr && i_reg_addr == blit_pkg::OFS_CTRL &&
		i_reg_wdata[0];

	property p_rd_hold;
		o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr);
	endproperty
	property p_wr_hold;
		o_mem_wr && !i_mem_ack |=> o_mem_wr && $stable(o_mem_addr) &&
			$stable(o_mem_wdata);
	endproperty
	property p_idle_quiet;
		!o_busy |-> !o_mem_rd && !o_mem_wr;
	endproperty
	property p_dst_read_first;
		$rose(o_mem_wr) |-> $past(o_mem_rd) && $past(i_mem_ack);
	endproperty
	// guarded by the past reset: a reset also drops the read request
	property p_read_ends_in_write;
		$past(i_rstn) && $fell(o_mem_rd) |-> o_mem_wr;
	endproperty
	property p_gap_after_wr;
		o_mem_wr && i_mem_ack |=> !o_mem_rd && !o_mem_wr;
	endproperty
	property p_busy_by_start;
		$rose(o_busy) |-> $past(start_wr);
	endproperty
	property p_line_lead;
		$rose(o_busy) |-> !o_mem_rd [*2] ##1 o_mem_rd;
	endproperty

	a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
	a_wr_hold: assert property (p_wr_hold) else $error("write moved");
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle access");
	a_dst_read_first: assert property (p_dst_read_first) else $error("no read");
	a_read_ends_in_write: assert property (p_read_ends_in_write) else $error("no wr");
	a_gap_after_wr: assert property (p_gap_after_wr) else $error("no gap");
	a_busy_by_start: assert property (p_busy_by_start) else $error("busy");
	a_line_lead: assert property (p_line_lead) else $error("line lead");

	// main scenarios: a run starts, a write lands, a slow read
	c_start: cover property ($rose(o_busy));
	c_write: cover property (o_mem_wr && i_mem_ack);
	c_slow: cover property (o_mem_rd && !i_mem_ack ##1 i_mem_ack);
endmodule

bind blit_engine blit_engine_properties #(.ADDR_W(ADDR_W), .DIM_W(DIM_W))
	blit_engine_properties_i (.i_ref_clk, .i_rstn, .i_reg_addr, .i_reg_wdata,
	.i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_mem_rd, .o_mem_wr, .o_mem_addr,
	.o_mem_wdata, .i_mem_rdata, .i_mem_ack, .i_ext_result, .o_busy);

// ### testbench/frame_mem.sv
// word-wide frame buffer memory with adjustable answer latency
`timescale 1ns/1ps
module frame_mem (
	// clock
	input  wire logic        i_ref_clk,
	// request from the engine
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_wdata,
	// idle cycles before each answer
	input  wire logic [1:0]  i_lat,
	// answer
	output logic      [15:0] o_rdata,
	output logic             o_ack
);
	logic [15:0] mem [0:255];
	logic [1:0]  wait_reg = 2'h0;
	wire         req = (i_rd | i_wr) & ~o_ack;
	wire         go  = req & (wait_reg == i_lat);

	// data outside the ack cycle toggles so a late sample never matches
	always @(posedge i_ref_clk) begin
		o_ack    <= go;
		o_rdata  <= go && i_rd ? mem[i_addr[7:0]] : ~o_rdata;
		wait_reg <= go || !req ? 2'h0 : wait_reg + 2'h1;
		if (go && i_wr)
			mem[i_addr[7:0]] <= i_wdata;
	end
endmodule

// ### testbench/bit_aligned_block_transfer_test.sv
// self-checking bench: setup writes, block runs, memory image compare
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module bit_aligned_block_transfer_test;
	localparam int          PITCH = 64;
	localparam logic [15:0] EXT   = 16'hC3A5;
	// op, invert, right-to-left, bottom-to-top, origins, width, lines
	// the last run ands a texture into the block the run before it moved,
	// so a three-operand result is built from two two-operand passes
	localparam int OP[10] = '{0, 1, 2, 3, 4, 5, 6, 4, 4, 0};
	localparam int IV[10] = '{0, 1, 0, 0, 1, 0, 0, 0, 0, 0};
	localparam int HR[10] = '{0, 1, 0, 1, 0, 0, 1, 1, 0, 0};
	localparam int VR[10] = '{0, 0, 1, 1, 0, 0, 1, 0, 0, 1};
	localparam int SO[10] = '{3, 70, 130, 17, 5, 9, 33, 3600, 3850, 40};
	localparam int DO[10] = '{2057, 2318, 2600, 2065, 2950, 3090, 3400, 3605,
		3722, 3722};
	localparam int WD[10] = '{29, 5, 40, 16, 3, 20, 25, 30, 20, 20};
	localparam int HT[10] = '{3, 2, 4, 2, 3, 2, 2, 2, 4, 4};

	logic        clk, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic        mem_rd, mem_wr, mem_ack, busy;
	logic [7:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, v;
	logic [19:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata, refm [0:255], orig [0:255];
	logic [1:0]  lat = 0;
	int          n_fail = 0, cmp_count = 0;

	blit_engine blit_engine_i (.i_ref_clk(clk), .i_rstn(rstn),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_mem_rd(mem_rd),
		.o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
		.i_mem_rdata(mem_rdata), .i_mem_ack(mem_ack), .i_ext_result(EXT),
		.o_busy(busy));
	frame_mem frame_mem_i (.i_ref_clk(clk), .i_rd(mem_rd), .i_wr(mem_wr),
		.i_addr(mem_addr), .i_wdata(mem_wdata), .i_lat(lat),
		.o_rdata(mem_rdata), .o_ack(mem_ack));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// each access starts on an edge, so strobes never clash in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// bit-level model: every pixel addressed as origin + y*pitch + x
	task automatic ref_blit(input int i);
		int   y, x, lo, hi, sb, db, dl;
		logic a, b, r;
		orig = refm;
		for (y = 0; y < HT[i]; y++) begin
			dl = DO[i] + y * PITCH;
			lo = OP[i] == 5 ? -(dl % 16) : 0;
			hi = OP[i] == 5 ? ((dl + WD[i] - 1) | 15) - dl : WD[i] - 1;
			for (x = lo; x <= hi; x++) begin
				sb = SO[i] + y * PITCH + x;
				db = dl + x;
				a  = orig[sb / 16][sb % 16] ^ (IV[i] == 1);
				b  = orig[db / 16][db % 16];
				case (OP[i])
					0: r = a & b;
					2: r = a ^ b;
					4: r = a;
					6: r = EXT[db % 16];
					default: r = a | b;
				endcase
				refm[db / 16][db % 16] = r;
			end
		end
	endtask

	task automatic run(input int i);
		int          k;
		logic [15:0] lm, rm;
		lm  = 16'hFFFF << (DO[i] % 16);
		rm  = 16'hFFFF >> (15 - (DO[i] % 16 + WD[i] - 1) % 16);
		lat <= 2'(i % 3);
		wr(blit_pkg::OFS_SRC_ORG, 32'(SO[i]));
		wr(blit_pkg::OFS_DST_ORG, 32'(DO[i]));
		wr(blit_pkg::OFS_PITCH, 32'(PITCH));
		wr(blit_pkg::OFS_WIDTH, 32'(WD[i]));
		wr(blit_pkg::OFS_HEIGHT, 32'(HT[i]));
		wr(blit_pkg::OFS_CTRL, 32'(OP[i] * 2 + IV[i] * 16 + HR[i] * 32 +
			VR[i] * 64 + 1));
		#1 `CHK(busy, 1'b1)
		// a setup change mid-run must not move the edge masks
		wr(blit_pkg::OFS_DST_ORG, 32'h0000_0000);
		#1;
		for (k = 0; k < 4000 && busy !== 1'b0; k++)
			#4;
		`CHK(busy, 1'b0)
		rd(blit_pkg::OFS_STATUS); `CHK(v, 32'h0000_0002)
		rd(blit_pkg::OFS_MASKS); `CHK(v, {rm, lm})
		// the mid-run origin write must have been refused
		rd(blit_pkg::OFS_DST_ORG); `CHK(v, 32'(DO[i]))
		rd(blit_pkg::OFS_SHIFT); `CHK(v, 32'((SO[i] - DO[i]) & 15))
		rd(blit_pkg::OFS_CTRL);
		`CHK(v, 32'(OP[i]*2 + IV[i]*16 + HR[i]*32 + VR[i]*64))
		ref_blit(i);
		for (k = 0; k < 256; k++)
			`CHK(frame_mem_i.mem[k], refm[k])
		// clear done so the next run has to set it afresh
		wr(blit_pkg::OFS_STATUS, 32'h0000_0002);
		rd(blit_pkg::OFS_STATUS); `CHK(v, 32'h0000_0000)
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// watchdog well above the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		for (int k = 0; k < 256; k++) begin
			refm[k] = 16'(k * 40503 + 12345);
			frame_mem_i.mem[k] = refm[k];
		end
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h40); `CHK(v, 32'h0000_0000)
		rd(blit_pkg::OFS_MASKS); `CHK(v, 32'hFFFF_FFFF)
		for (int i = 0; i < 10; i++)
			run(i);
		end_of_test();
	end
endmodule
